/* inc/spi_host_pkg.sv */
package spi_host_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] TX_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] RX_OFS = 4'h8;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'hc;
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_RNW_BIT = 1;
   localparam int CTRL_3W_BIT = 2;
   localparam int CTRL_ADDR_LSB = 8;
   localparam int CTRL_NB_LSB = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RESET_WORD = 32'h0;
   // Sensor's own output format register, written by software through a transfer
   localparam logic [5:0] OUTPUT_FORMAT_CONTROL_ADDR = 6'h31;
   localparam longint CLK_HZ = 20000000;
   localparam longint SCLK_MAX_HZ = 5000000;
   // Run below the ceiling so the pin synchroniser latency fits in a half period
   localparam longint SCLK_HZ = 2500000;
   localparam int SCLK_HALF_CYC = int'((CLK_HZ + 2 * SCLK_HZ - 1) / (2 * SCLK_HZ));
   localparam longint CS_GAP_NS = 250;
   localparam int CS_GAP_CYC = int'((CS_GAP_NS * CLK_HZ + 999999999) / 1000000000);
   localparam longint SDO_DIS_NS = 100;
   localparam int SDO_DIS_CYC = int'((SDO_DIS_NS * CLK_HZ + 999999999) / 1000000000);
   localparam logic [2:0] DIV_LAST = 3'(SCLK_HALF_CYC - 1);
   localparam logic [2:0] GAP_LAST = 3'(CS_GAP_CYC - 1);
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SETUP = 2'h1,
      ST_SHIFT = 2'h3,
      ST_GAP = 2'h2
   } state_t;
endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic q1;
      logic q2;
      logic q3;
      logic val;
   } sync_t;
   sync_t s_ff;
   sync_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.q1 = din;
      nxt_s.q2 = s_ff.q1;
      nxt_s.q3 = s_ff.q2;
      // A change counts once two later stages agree
      if (s_ff.q2 == s_ff.q3) begin
         nxt_s.val = s_ff.q3;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= 4'hf;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign dout = s_ff.val;
endmodule

/* rtl/spi_host.sv */
`timescale 1ns/1ps
module spi_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [spi_host_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [spi_host_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic cs_n,
   output logic sclk,
   output logic sdi_o,
   output logic sdi_oe,
   input wire logic sdi_i,
   input wire logic sdo_i
);
   import spi_host_pkg::*;

   typedef struct packed {
      state_t state;
      logic [2:0] div;
      logic [2:0] gap;
      logic phase;
      logic [5:0] bit_cnt;
      logic cs_n;
      logic sclk;
      logic sdi;
      logic sdi_oe;
      logic rnw;
      logic three;
      logic [5:0] addr;
      logic [1:0] nb;
      logic [31:0] tx;
      logic [31:0] rx;
      logic done;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] waddr;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } st_t;

   st_t st_ff;
   st_t nxt_st;
   logic sdo_f;
   logic sdio_f;
   logic din;
   logic tick;
   logic go;
   logic done_clr;
   logic done_set;
   logic idle;
   logic [31:0] ctrl_rd;
   logic [31:0] stat_rd;
   logic [31:0] wr;
   logic [5:0] total;
   logic [4:0] k_out;
   logic [4:0] k_in;
   logic [7:0] hdr;
   logic out_bit;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] neu,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = neu[i*8 +: 8];
         end
      end
      return res;
   endfunction

   pin_sync u_sdo_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(sdo_i),
      .dout(sdo_f)
   );

   pin_sync u_sdio_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(sdi_i),
      .dout(sdio_f)
   );

   assign din = st_ff.three ? sdio_f : sdo_f;
   assign idle = (st_ff.state == ST_IDLE);
   assign tick = (st_ff.div == DIV_LAST);
   // Header then 1..4 data bytes; always whole bytes so no byte is cut short
   assign total = {3'(({1'b0, st_ff.nb}) + 3'h2), 3'h0};
   assign hdr = {st_ff.rnw, (st_ff.nb != 2'h0), st_ff.addr};
   assign k_out = 5'(st_ff.bit_cnt - 6'h08);
   assign k_in = 5'(st_ff.bit_cnt - 6'h09);
   // Byte 0 is in bits 7..0 and goes first, each byte MSB first
   assign out_bit = (st_ff.bit_cnt < 6'h08) ? hdr[3'h7 - st_ff.bit_cnt[2:0]]
                                            : st_ff.tx[{k_out[4:3], ~k_out[2:0]}];
   assign ctrl_rd = {14'h0, st_ff.nb, 2'h0, st_ff.addr, 5'h0, st_ff.three, st_ff.rnw, 1'b0};
   assign stat_rd = {30'h0, st_ff.done, !idle};

   always_comb begin
      nxt_st = st_ff;
      go = 1'b0;
      done_clr = 1'b0;
      done_set = 1'b0;
      wr = RESET_WORD;
      if (awvalid && st_ff.awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.waddr = awaddr;
      end
      if (wvalid && st_ff.wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdat = wdata;
         nxt_st.wstb = wstrb;
      end
      if (bready && st_ff.bvalid) begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         case (st_ff.waddr)
            CTRL_OFS: begin
               // Settings are frozen while a transfer runs
               wr = merge(ctrl_rd, st_ff.wdat, st_ff.wstb);
               if (idle) begin
                  nxt_st.rnw = wr[CTRL_RNW_BIT];
                  nxt_st.three = wr[CTRL_3W_BIT];
                  nxt_st.addr = wr[CTRL_ADDR_LSB +: 6];
                  nxt_st.nb = wr[CTRL_NB_LSB +: 2];
                  go = st_ff.wstb[0] && st_ff.wdat[CTRL_GO_BIT];
               end
            end
            TX_OFS: begin
               if (idle) begin
                  nxt_st.tx = merge(st_ff.tx, st_ff.wdat, st_ff.wstb);
               end
            end
            STATUS_OFS: begin
               done_clr = st_ff.wstb[0] && st_ff.wdat[STAT_DONE_BIT];
            end
            RX_OFS: begin
               nxt_st.bresp = RESP_OKAY;
            end
            default: begin
               nxt_st.bresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

      if (rready && st_ff.rvalid) begin
         nxt_st.rvalid = 1'b0;
      end
      if (arvalid && st_ff.arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         case (araddr)
            CTRL_OFS: nxt_st.rdata = ctrl_rd;
            TX_OFS: nxt_st.rdata = st_ff.tx;
            RX_OFS: nxt_st.rdata = st_ff.rx;
            STATUS_OFS: nxt_st.rdata = stat_rd;
            default: begin
               nxt_st.rdata = RESET_WORD;
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_st.arready = !nxt_st.rvalid;

      if (idle || tick) begin
         nxt_st.div = 3'h0;
      end else begin
         nxt_st.div = 3'(st_ff.div + 3'h1);
      end
      case (st_ff.state)
         ST_IDLE: begin
            // Every line is driven and the data line parked high while idle
            nxt_st.cs_n = 1'b1;
            nxt_st.sclk = 1'b1;
            nxt_st.sdi = 1'b1;
            nxt_st.sdi_oe = 1'b1;
            if (go) begin
               nxt_st.state = ST_SETUP;
               nxt_st.cs_n = 1'b0;
               nxt_st.bit_cnt = 6'h0;
               nxt_st.phase = 1'b0;
            end
         end
         ST_SETUP: begin
            if (tick) begin
               nxt_st.state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (tick) begin
               if (!st_ff.phase) begin
                  // Sample a half period after the rise, covering sync latency
                  if (st_ff.rnw && st_ff.bit_cnt >= 6'h09) begin
                     nxt_st.rx[{k_in[4:3], ~k_in[2:0]}] = din;
                  end
                  if (st_ff.bit_cnt == total) begin
                     nxt_st.state = ST_GAP;
                     nxt_st.cs_n = 1'b1;
                     nxt_st.sdi = 1'b1;
                     nxt_st.gap = 3'h0;
                  end else begin
                     nxt_st.sclk = 1'b0;
                     nxt_st.sdi = out_bit;
                     nxt_st.sdi_oe = !(st_ff.three && st_ff.rnw && st_ff.bit_cnt >= 6'h08);
                     nxt_st.phase = 1'b1;
                  end
               end else begin
                  nxt_st.sclk = 1'b1;
                  nxt_st.bit_cnt = 6'(st_ff.bit_cnt + 6'h01);
                  nxt_st.phase = 1'b0;
               end
            end
         end
         ST_GAP: begin
            // Shared line stays released past the sensor's output disable time
            nxt_st.gap = 3'(st_ff.gap + 3'h1);
            if (st_ff.gap == GAP_LAST) begin
               nxt_st.state = ST_IDLE;
               // Retake the line together with idle, so idle never sees it floating
               nxt_st.sdi_oe = 1'b1;
               done_set = 1'b1;
            end
         end
         default: begin
            nxt_st.state = ST_IDLE;
         end
      endcase
      // Completion wins over a clear in the same cycle
      nxt_st.done = (st_ff.done && !done_clr) || done_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.state <= ST_IDLE;
         st_ff.cs_n <= 1'b1;
         st_ff.sclk <= 1'b1;
         st_ff.sdi <= 1'b1;
         st_ff.sdi_oe <= 1'b1;
         st_ff.awready <= 1'b1;
         st_ff.wready <= 1'b1;
         st_ff.arready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign awready = st_ff.awready;
   assign wready = st_ff.wready;
   assign bvalid = st_ff.bvalid;
   assign bresp = st_ff.bresp;
   assign arready = st_ff.arready;
   assign rvalid = st_ff.rvalid;
   assign rdata = st_ff.rdata;
   assign rresp = st_ff.rresp;
   assign cs_n = st_ff.cs_n;
   assign sclk = st_ff.sclk;
   assign sdi_o = st_ff.sdi;
   assign sdi_oe = st_ff.sdi_oe;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   idle_park_a: assert property (idle |-> cs_n && sclk && sdi_o && sdi_oe)
      else $error("lines not parked while idle");
   clk_in_frame_a: assert property (!sclk |-> !cs_n)
      else $error("serial clock low outside a frame");
   low_time_a: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
      else $error("serial clock low time wrong");
   high_time_a: assert property ($rose(sclk) && !cs_n |-> sclk [*4])
      else $error("serial clock high time too short");
   data_stable_a: assert property ($rose(sclk) |-> $stable(sdi_o))
      else $error("data changed at rising clock");
   rw_flag_a: assert property (st_ff.state == ST_SHIFT && tick && !st_ff.phase
                               && st_ff.bit_cnt == 6'h00 |=> sdi_o == st_ff.rnw)
      else $error("first bit is not the read flag");
   mb_flag_a: assert property (st_ff.state == ST_SHIFT && tick && !st_ff.phase
                               && st_ff.bit_cnt == 6'h01 |=> sdi_o == (st_ff.nb != 2'h0))
      else $error("second bit is not the multi-byte flag");
   three_release_a: assert property (st_ff.state == ST_SHIFT && st_ff.three && st_ff.rnw
                                     && st_ff.phase && st_ff.bit_cnt >= 6'h08 |-> !sdi_oe)
      else $error("shared line driven during read data");
   gap_release_a: assert property ($rose(cs_n) && st_ff.three && st_ff.rnw
                                   |-> !sdi_oe [*5] ##1 sdi_oe)
      else $error("shared line retaken too early");
   cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*6])
      else $error("chip select gap too short");
   whole_byte_a: assert property ($rose(cs_n) |-> st_ff.bit_cnt[2:0] == 3'h0
                                  && st_ff.bit_cnt == total)
      else $error("frame ended mid-byte");
   write_keep_a: assert property (st_ff.state == ST_SHIFT && !st_ff.rnw |=> $stable(st_ff.rx))
      else $error("read data changed during a write");
   done_set_a: assert property (st_ff.state == ST_GAP && st_ff.gap == GAP_LAST |=> st_ff.done)
      else $error("done not set at end of frame");

   write4_c: cover property ($rose(cs_n) && !st_ff.rnw && !st_ff.three);
   read3_c: cover property ($rose(cs_n) && st_ff.rnw && st_ff.three);
   burst_c: cover property ($rose(cs_n) && st_ff.rnw && st_ff.nb == 2'h3);
   slverr_c: cover property (bvalid && bresp == RESP_SLVERR);
endmodule

/* test/sensor_model.sv */
`timescale 1ns/1ps
module sensor_model #(
   parameter int WIRE_BIT = 6
) (
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic dout,
   output logic sdo_oe,
   output logic sio_oe
);
   logic [7:0] regs [64];
   logic [7:0] sh;
   logic [7:0] hdr;
   logic [7:0] outb;
   logic [5:0] ptr;
   logic drv = 1'h0;
   int cnt;
   wire three_w = regs[6'h31][WIRE_BIT];
   assign sdo_oe = drv & !three_w;
   assign sio_oe = drv & three_w;
   initial begin
      dout = 1'h0;
      hdr = 8'h0;
      cnt = 0;
      foreach (regs[i]) regs[i] = 8'h0;
   end
   // Only ever reacts to the host's pins, never starts anything
   always @(negedge cs_n) begin
      cnt = 0;
      hdr = 8'h0;
   end
   always @(posedge sclk) if (!cs_n) begin
      sh = {sh[6:0], sdi};
      cnt++;
      if (cnt == 8) begin
         hdr = sh;
         ptr = sh[5:0];
      end else if (cnt % 8 == 0) begin
         if (!hdr[7]) regs[ptr] = sh;
         if (hdr[6]) ptr++;
      end
   end
   // Read data only, so the line stays free during writes
   always @(negedge sclk) if (!cs_n && cnt >= 8 && hdr[7]) begin
      if (cnt % 8 == 0) outb = regs[ptr];
      dout <= #20 outb[7];
      drv <= #20 1'h1;
      outb = {outb[6:0], 1'h0};
   end
   // Released value flips so a stale bit can never be read as data
   always @(posedge cs_n) begin
      #60 drv = 1'h0;
      dout = ~dout;
   end
endmodule

/* test/tb_spi_host.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_spi_host;
   import spi_host_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic [ADDR_W-1:0] awaddr = 4'h0;
   logic [ADDR_W-1:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, cs_n, sclk, sdi_o, sdi_oe;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, rx;
   logic dout, sdo_oe, sio_oe, line;
   logic tog = 1'h0;
   logic [ADDR_W-1:0] ofs [4] = '{CTRL_OFS, TX_OFS, RX_OFS, STATUS_OFS};
   int n_fail = 0;
   int n_tests = 0;
   realtime t_fall = 0;
   always #25 aclk = ~aclk;
   // Undriven line shows a changing level instead of a settled guess
   always @(posedge aclk) tog <= ~tog;
   assign line = sdi_oe ? sdi_o : (sio_oe ? dout : tog);
   spi_host i_spi_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .cs_n(cs_n), .sclk(sclk), .sdi_o(sdi_o), .sdi_oe(sdi_oe), .sdi_i(line),
      .sdo_i(sdo_oe ? dout : tog));
   sensor_model i_sensor_model (.cs_n(cs_n), .sclk(sclk), .sdi(line), .dout(dout),
      .sdo_oe(sdo_oe), .sio_oe(sio_oe));
   always @(negedge sclk) t_fall = $realtime;
   // Reset takes the clock out of unknown, which is no real rising edge
   always @(posedge sclk) if (aresetn) `CHK($realtime - t_fall >= 100.0, 1'h1)
   always @(posedge aclk) if (aresetn) `CHK(sdi_oe & sio_oe, 1'h0)
   always @(posedge aclk) if (aresetn && cs_n && sdi_oe) `CHK({sclk, sdi_o}, 2'h3)
   task automatic wrap_up();
      if (n_fail == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic bound(input int n);
      if (n >= 300) begin
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                         output logic [1:0] rsp);
      int n;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 300; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      rsp = bresp;
      bready <= 1'h0;
      bound(n);
   endtask
   task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                         output logic [1:0] rsp);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 300; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      d = rdata;
      rsp = rresp;
      rready <= 1'h0;
      bound(n);
   endtask
   task automatic xfer(input logic rnw, input logic tw, input logic [5:0] a,
                       input logic [1:0] nb, input logic [31:0] tx);
      axi_wr(TX_OFS, tx, r);
      axi_wr(CTRL_OFS, {14'h0, nb, 2'h0, a, 5'h0, tw, rnw, 1'h1}, r);
   endtask
   task automatic finish_x();
      int n;
      for (n = 0; n < 300; n++) begin
         axi_rd(STATUS_OFS, rx, r);
         if (rx[STAT_DONE_BIT]) break;
      end
      bound(n);
      `CHK(rx[STAT_BUSY_BIT], 1'h0)
      axi_wr(STATUS_OFS, 32'h2, r);
      axi_rd(RX_OFS, rx, r);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      `CHK({cs_n, sclk, sdi_o}, 3'h7)
      axi_wr(RX_OFS, 32'hff, r);
      `CHK(r, RESP_OKAY)
      for (int i = 0; i < 4; i++) begin
         axi_rd(ofs[i], rx, r);
         `CHK({r, rx}, {RESP_OKAY, RESET_WORD})
      end
      axi_rd(4'h6, rx, r);
      `CHK({r, rx}, {RESP_SLVERR, 32'h0})
      axi_wr(4'h2, 32'h1, r);
      `CHK(r, RESP_SLVERR)
      xfer(1'h0, 1'h0, 6'h10, 2'h0, 32'ha5);
      finish_x();
      `CHK(i_sensor_model.regs[16], 8'ha5)
      xfer(1'h1, 1'h0, 6'h10, 2'h0, 32'h0);
      finish_x();
      `CHK(rx[7:0], 8'ha5)
      xfer(1'h0, 1'h0, 6'h20, 2'h3, 32'h44332211);
      finish_x();
      `CHK({i_sensor_model.regs[35], i_sensor_model.regs[34], i_sensor_model.regs[33],
            i_sensor_model.regs[32]}, 32'h44332211)
      xfer(1'h1, 1'h0, 6'h21, 2'h2, 32'h0);
      finish_x();
      `CHK(rx[23:0], 24'h443322)
      // Second request lands mid-frame and must be dropped
      xfer(1'h0, 1'h0, 6'h08, 2'h3, 32'h0c0b0a09);
      xfer(1'h0, 1'h0, 6'h30, 2'h0, 32'h77);
      finish_x();
      `CHK({i_sensor_model.regs[11], i_sensor_model.regs[8]}, 16'h0c09)
      `CHK(i_sensor_model.regs[48], 8'h00)
      axi_rd(TX_OFS, rx, r);
      `CHK(rx, 32'h0c0b0a09)
      xfer(1'h0, 1'h0, OUTPUT_FORMAT_CONTROL_ADDR, 2'h0, 32'h40);
      finish_x();
      xfer(1'h0, 1'h1, 6'h12, 2'h0, 32'h5a);
      finish_x();
      `CHK(i_sensor_model.regs[18], 8'h5a)
      xfer(1'h1, 1'h1, 6'h12, 2'h0, 32'h0);
      finish_x();
      `CHK(rx[7:0], 8'h5a)
      xfer(1'h1, 1'h1, 6'h20, 2'h1, 32'h0);
      finish_x();
      `CHK(rx[15:0], 16'h2211)
      axi_rd(STATUS_OFS, rx, r);
      `CHK(rx, 32'h0)
      wrap_up();
   end
   initial begin
      repeat (100000) @(posedge aclk);
      n_fail++;
      wrap_up();
   end
endmodule
